// ### bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic gev = 1'b0;
  logic gen = 1'b0;
  logic gclr = 1'b0;
  logic gflag, irq_n, irq_oe_n, irq_line;
  logic [11:0] done = 12'h000;
  logic [11:0] busy = 12'h000;
  logic [15:0] rdata;
  tsirq_pkg::tsirq_reg_req_t req = '0;
  tsirq_pkg::tsirq_touch_t touch = '0;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;

  tsirq_top DUT (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .reg_req_in(req), .reg_rdata_out(rdata), .stage_done_in(done),
    .stage_busy_in(busy), .touch_in(touch), .gpio_event_in(gev),
    .gpio_irq_enable_in(gen), .gpio_irq_clear_in(gclr),
    .gpio_irq_flag_out(gflag), .irq_n_out(irq_n),
    .irq_oe_n_out(irq_oe_n));
  tsirq_host_model host (.irq_n_in(irq_n), .irq_oe_n_in(irq_oe_n),
    .irq_line_out(irq_line));

  initial forever #25 sys_clk_in = ~sys_clk_in;

  task automatic conclude;
    if (err_total == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic chk(string what, logic [15:0] got, logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // idle cycle after each strobe keeps strobes one cycle wide
  task automatic access(logic [9:0] a, logic w, logic [15:0] d);
    req = '{addr: a, wr: w, rd: !w, wdata: d};
    @(negedge sys_clk_in);
    req = '0;
    @(negedge sys_clk_in);
  endtask : access

  task automatic rd(logic [9:0] a, logic [15:0] e);
    access(a, 1'b0, 16'h0000);
    chk("rdata", rdata, e);
  endtask : rd

  // two reads back to back: strobe held for two edges
  task automatic rd_pair(logic [9:0] a, logic [15:0] e);
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
    repeat (2) @(negedge sys_clk_in);
    req = '0;
    @(negedge sys_clk_in);
    chk("rdata", rdata, e);
  endtask : rd_pair

  task automatic line(logic e);
    chk("irq_line", 16'(irq_line), 16'(e));
  endtask : line

  task automatic fire(logic [11:0] v);
    done = v;
    @(negedge sys_clk_in);
    done = 12'h000;
    @(negedge sys_clk_in);
  endtask : fire

  task automatic act(logic [15:0] v, logic e);
    touch.act_a = v;
    @(negedge sys_clk_in);
    @(negedge sys_clk_in);
    line(e);
  endtask : act

  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      conclude();
    end
  end

  initial begin
    repeat (12) @(negedge sys_clk_in);
    rstn_in = 1'b1;
    line(1'b1);
    rd(10'h005, 16'h0000);
    access(10'h007, 1'b1, 16'h0010);
    rd(10'h007, 16'h0010);
    rd(10'h3FF, 16'h0000);
    fire(12'h00F);
    line(1'b1);
    fire(12'h010);
    line(1'b0);
    access(10'h00A, 1'b1, 16'hFFFF);
    rd(10'h00A, 16'h0010);
    line(1'b1);
    busy = 12'h010;
    fire(12'h010);
    rd(10'h00A, 16'h0010);
    rd(10'h00A, 16'h0010);
    busy = 12'h000;
    rd(10'h00A, 16'h0010);
    rd(10'h00A, 16'h0000);
    line(1'b1);
    done = 12'h010;
    @(negedge sys_clk_in);
    done = 12'h000;
    line(1'b0);
    rd_pair(10'h00A, 16'h0000);
    line(1'b1);
    access(10'h005, 1'b1, 16'hFFFF);
    rd(10'h005, 16'h0FFF);
    act(16'h0001, 1'b0);
    rd(10'h008, 16'h0001);
    line(1'b0);
    rd(10'h009, 16'h0000);
    line(1'b1);
    act(16'h0003, 1'b0);
    rd(10'h009, 16'h0000);
    rd(10'h008, 16'h0003);
    act(16'h0000, 1'b0);
    rd(10'h008, 16'h0000);
    rd(10'h009, 16'h0000);
    line(1'b1);
    access(10'h006, 1'b1, 16'h0002);
    rd(10'h006, 16'h0002);
    touch.act_b = 16'h0006;
    repeat (2) @(negedge sys_clk_in);
    line(1'b0);
    rd(10'h009, 16'h0002);
    line(1'b0);
    rd(10'h008, 16'h0000);
    line(1'b1);
    gen = 1'b1;
    gev = 1'b1;
    @(negedge sys_clk_in);
    gev = 1'b0;
    chk("gpio_flag", 16'(gflag), 16'h0001);
    line(1'b0);
    gclr = 1'b1;
    @(negedge sys_clk_in);
    gclr = 1'b0;
    @(negedge sys_clk_in);
    line(1'b1);
    conclude();
  end
endmodule : tb_top

`default_nettype wire

// ### bench/tsirq_asserts.sv
`timescale 1ns/1ns
`default_nettype none

module tsirq_checker #(
  parameter int NUM_STAGES = 12
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // register port and events
  input wire tsirq_pkg::tsirq_reg_req_t reg_req_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic [NUM_STAGES-1:0] stage_done_in,
  input wire logic [NUM_STAGES-1:0] stage_busy_in,
  input wire tsirq_pkg::tsirq_touch_t touch_in,
  input wire logic gpio_event_in,
  input wire logic gpio_irq_enable_in,
  input wire logic gpio_irq_flag_out,
  // request line
  input wire logic irq_n_out,
  input wire logic irq_oe_n_out
);
  localparam logic [15:0] LIM = 16'((32'h1 << NUM_STAGES) - 1);
  logic [15:0] ena;
  logic [15:0] msk;
  logic [15:0] done16;
  logic [15:0] busy16;
  assign done16 = 16'(stage_done_in);
  assign busy16 = 16'(stage_busy_in);
  // shadow of the enables, built only from port traffic
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      ena <= 16'h0000;
      msk <= 16'h0000;
    end else if (reg_req_in.wr) begin
      if (reg_req_in.addr == 10'h005) ena <= reg_req_in.wdata & LIM;
      if (reg_req_in.addr == 10'h007) msk <= reg_req_in.wdata & LIM;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_rd(a);
    reg_req_in.rd && reg_req_in.addr == a;
  endsequence
  sequence s_fire;
    (done16 & msk) != 16'h0000 ##1 s_rd(10'h00A);
  endsequence
  property p_od;
    irq_n_out == 1'b0;
  endproperty
  property p_done;
    (done16 & msk) != 16'h0000 |=> !irq_oe_n_out;
  endproperty
  property p_flag;
    s_fire |=> (reg_rdata_out & $past(done16 & msk, 2))
      == $past(done16 & msk, 2);
  endproperty
  property p_clear;
    s_rd(10'h00A) ##1 s_rd(10'h00A) |=> reg_rdata_out ==
      (($past(reg_rdata_out) & $past(busy16 | done16, 2))
      | $past(done16 & msk, 2));
  endproperty
  property p_mask;
    s_rd(10'h007) |=> reg_rdata_out == $past(msk);
  endproperty
  property p_touch;
    ((touch_in.act_a ^ $past(touch_in.act_a)) & ena) != 16'h0000
      |=> !irq_oe_n_out;
  endproperty
  property p_stat;
    s_rd(10'h008) |=> reg_rdata_out == $past(touch_in.act_a & ena);
  endproperty
  property p_gpio;
    gpio_event_in && gpio_irq_enable_in |=>
      gpio_irq_flag_out && !irq_oe_n_out;
  endproperty
  a_od: assert property (p_od) else $error("line data not low");
  a_done: assert property (p_done) else $error("no done request");
  a_flag: assert property (p_flag) else $error("done flag lost");
  a_clear: assert property (p_clear) else $error("bad flag clear");
  a_mask: assert property (p_mask) else $error("mask readback");
  a_touch: assert property (p_touch) else $error("no touch request");
  a_stat: assert property (p_stat) else $error("touch status");
  a_gpio: assert property (p_gpio) else $error("no gpio request");
endmodule : tsirq_checker

bind tsirq_top tsirq_checker #(.NUM_STAGES(NUM_STAGES)) u_chk (
  .sys_clk_in(sys_clk_in),
  .rstn_in(rstn_in),
  .reg_req_in(reg_req_in),
  .reg_rdata_out(reg_rdata_out),
  .stage_done_in(stage_done_in),
  .stage_busy_in(stage_busy_in),
  .touch_in(touch_in),
  .gpio_event_in(gpio_event_in),
  .gpio_irq_enable_in(gpio_irq_enable_in),
  .gpio_irq_flag_out(gpio_irq_flag_out),
  .irq_n_out(irq_n_out),
  .irq_oe_n_out(irq_oe_n_out)
);

`default_nettype wire

// ### bench/tsirq_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module tsirq_host_model (
  // pin from the device
  input wire logic irq_n_in,
  input wire logic irq_oe_n_in,
  // level seen by the host
  output logic irq_line_out
);
  // board pull-up holds the line high once released
  assign irq_line_out = irq_oe_n_in ? 1'b1 : irq_n_in;
endmodule : tsirq_host_model

`default_nettype wire

// ### logic/tsirq_map.svh
`ifndef TSIRQ_MAP_SVH
`define TSIRQ_MAP_SVH

// register word offsets on the serial register port
`define TSIRQ_ADDR_W 10
`define TSIRQ_DATA_W 16
`define TSIRQ_OFS_TOUCH_EN_A 10'h005
`define TSIRQ_OFS_TOUCH_EN_B 10'h006
`define TSIRQ_OFS_STAGE_MASK 10'h007
`define TSIRQ_OFS_TOUCH_FLAGS_A 10'h008
`define TSIRQ_OFS_TOUCH_FLAGS_B 10'h009
`define TSIRQ_OFS_STAGE_FLAGS 10'h00A

// reset values
`define TSIRQ_RST_ENABLE 16'h0000
`define TSIRQ_RST_RDATA 16'h0000

`endif

// ### logic/tsirq_pkg.sv
`default_nettype none

package tsirq_pkg;

  // one register access as seen behind the serial interface
  typedef struct packed {
    logic [9:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } tsirq_reg_req_t;

  // per-stage touch activation, low and high limit
  typedef struct packed {
    logic [15:0] act_a;
    logic [15:0] act_b;
  } tsirq_touch_t;

endpackage : tsirq_pkg

`default_nettype wire

// ### logic/tsirq_sticky.sv
`timescale 1ns/1ns
`default_nettype none

module tsirq_sticky #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // events
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] cond_in,
  input wire logic clr_in,
  // state
  output logic [W-1:0] flags_out,
  output logic [W-1:0] next_flags_out
);

  // only widths that fit one register word are served
  if (W < 1 || W > 16) begin : g_bad_width
    $error("tsirq_sticky: W out of range");
  end

  // a flag whose cause is still present survives the clearing read;
  // a new event in the clearing cycle wins over the clear
  assign next_flags_out = (flags_out & ~({W{clr_in}} & ~cond_in)) | set_in;

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      flags_out <= '0;
    end else begin
      flags_out <= next_flags_out;
    end
  end

endmodule : tsirq_sticky

`default_nettype wire

// ### logic/tsirq_top.sv
// Notes on behaviour
// - three sources: stage done, touch, general input; each has enable and status.
// - request line is open drain, pulled low to request, released otherwise.
// - done and touch requests enabled per stage; status names the cause.
// - status read clears flags; line releases once read address is set up.
// - enabled stage finishing with new result pulls the line low.
// - stage done mask holds one enable bit per stage, 1 enables.
// - stage done flags hold one bit per stage, set when a masked-in stage fires.
// - flag read clears a bit only when its cause is gone.
// - touch mode requests on first contact and again on release.
// - touch enables live in two registers, offsets 0x005 and 0x006.
// - touch status reads from two registers, offsets 0x008 and 0x009.
// - after a touch request, line stays low until both touch statuses read.
// - a touch status change raises a request only on an activation edge of an enabled sensor; enable writes alone do not.
// - touch status read returns enabled sensors active at the moment of read.
`timescale 1ns/1ns
`default_nettype none
`include "tsirq_map.svh"

module tsirq_top #(
  parameter int NUM_STAGES = 12
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // register port behind the serial interface
  input wire tsirq_pkg::tsirq_reg_req_t reg_req_in,
  output logic [15:0] reg_rdata_out,
  // converter and sensor events
  input wire logic [NUM_STAGES-1:0] stage_done_in,
  input wire logic [NUM_STAGES-1:0] stage_busy_in,
  input wire tsirq_pkg::tsirq_touch_t touch_in,
  // general purpose input event
  input wire logic gpio_event_in,
  input wire logic gpio_irq_enable_in,
  input wire logic gpio_irq_clear_in,
  output logic gpio_irq_flag_out,
  // open-drain request line
  output logic irq_n_out,
  output logic irq_oe_n_out
);

  // one status bit per stage must fit a register word
  if (NUM_STAGES < 1 || NUM_STAGES > `TSIRQ_DATA_W) begin : g_bad_stages
    $error("tsirq_top: NUM_STAGES must be 1 to 16");
  end

  localparam int N = NUM_STAGES;

  logic [N-1:0] touch_en_a;
  logic [N-1:0] touch_en_b;
  logic [N-1:0] stage_mask;
  logic [N-1:0] stage_flags;
  logic [N-1:0] next_stage_flags;
  logic gpio_flag;
  logic next_gpio_flag;
  logic touch_pending;
  logic next_touch_pending;
  logic next_irq;
  logic rd_touch_a;
  logic rd_touch_b;
  logic rd_stage;
  logic wr_hit;
  logic [15:0] next_rdata;

  // decode of read strobe, which marks the address phase
  assign rd_touch_a = reg_req_in.rd &&
                      reg_req_in.addr == `TSIRQ_OFS_TOUCH_FLAGS_A;
  assign rd_touch_b = reg_req_in.rd &&
                      reg_req_in.addr == `TSIRQ_OFS_TOUCH_FLAGS_B;
  assign rd_stage = reg_req_in.rd &&
                    reg_req_in.addr == `TSIRQ_OFS_STAGE_FLAGS;
  assign wr_hit = reg_req_in.wr;

  // enable registers
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      touch_en_a <= N'(`TSIRQ_RST_ENABLE);
      touch_en_b <= N'(`TSIRQ_RST_ENABLE);
      stage_mask <= N'(`TSIRQ_RST_ENABLE);
    end else if (wr_hit) begin
      unique case (reg_req_in.addr)
        `TSIRQ_OFS_TOUCH_EN_A: begin
          touch_en_a <= reg_req_in.wdata[N-1:0];
        end
        `TSIRQ_OFS_TOUCH_EN_B: begin
          touch_en_b <= reg_req_in.wdata[N-1:0];
        end
        `TSIRQ_OFS_STAGE_MASK: begin
          stage_mask <= reg_req_in.wdata[N-1:0];
        end
        default: begin
          // status and unmapped words ignore writes
        end
      endcase
    end
  end

  // stage done flags: only masked-in stages ever set a bit
  tsirq_sticky #(
    .W(N)
  ) u_stage_flags (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .set_in(stage_done_in & stage_mask),
    .cond_in(stage_busy_in | stage_done_in),
    .clr_in(rd_stage),
    .flags_out(stage_flags),
    .next_flags_out(next_stage_flags)
  );

  // general purpose input source, cleared by its own strobe
  tsirq_sticky #(
    .W(1)
  ) u_gpio_flag (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .set_in(gpio_event_in & gpio_irq_enable_in),
    .cond_in(1'b0),
    .clr_in(gpio_irq_clear_in),
    .flags_out(gpio_flag),
    .next_flags_out(next_gpio_flag)
  );

  tsirq_touch_watch #(
    .W(N)
  ) u_touch (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .act_a_in(touch_in.act_a[N-1:0]),
    .act_b_in(touch_in.act_b[N-1:0]),
    .en_a_in(touch_en_a),
    .en_b_in(touch_en_b),
    .rd_a_in(rd_touch_a),
    .rd_b_in(rd_touch_b),
    .pending_out(touch_pending),
    .next_pending_out(next_touch_pending)
  );

  // built from post-clear values so the line lets go at the address edge
  assign next_irq = (|next_stage_flags) | next_gpio_flag |
                    next_touch_pending;

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      irq_n_out <= 1'b0;
      irq_oe_n_out <= 1'b1;
    end else begin
      irq_n_out <= 1'b0;
      irq_oe_n_out <= ~next_irq;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      gpio_irq_flag_out <= 1'b0;
    end else begin
      gpio_irq_flag_out <= next_gpio_flag;
    end
  end

  // read data; touch status shows live activations, not latched ones
  always_comb begin
    next_rdata = `TSIRQ_RST_RDATA;
    unique case (reg_req_in.addr)
      `TSIRQ_OFS_TOUCH_EN_A: next_rdata[N-1:0] = touch_en_a;
      `TSIRQ_OFS_TOUCH_EN_B: next_rdata[N-1:0] = touch_en_b;
      `TSIRQ_OFS_STAGE_MASK: next_rdata[N-1:0] = stage_mask;
      `TSIRQ_OFS_TOUCH_FLAGS_A: begin
        next_rdata[N-1:0] = touch_in.act_a[N-1:0] & touch_en_a;
      end
      `TSIRQ_OFS_TOUCH_FLAGS_B: begin
        next_rdata[N-1:0] = touch_in.act_b[N-1:0] & touch_en_b;
      end
      `TSIRQ_OFS_STAGE_FLAGS: next_rdata[N-1:0] = stage_flags;
      default: next_rdata = `TSIRQ_RST_RDATA;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= `TSIRQ_RST_RDATA;
    end else if (reg_req_in.rd) begin
      reg_rdata_out <= next_rdata;
    end
  end

endmodule : tsirq_top

`default_nettype wire

// ### logic/tsirq_touch_watch.sv
`timescale 1ns/1ns
`default_nettype none

module tsirq_touch_watch #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // activations and enables
  input wire logic [W-1:0] act_a_in,
  input wire logic [W-1:0] act_b_in,
  input wire logic [W-1:0] en_a_in,
  input wire logic [W-1:0] en_b_in,
  // status reads
  input wire logic rd_a_in,
  input wire logic rd_b_in,
  // pending request
  output logic pending_out,
  output logic next_pending_out
);

  logic [W-1:0] prev_a;
  logic [W-1:0] prev_b;
  logic seen_a;
  logic seen_b;
  logic change;
  logic both_read;

  // any enabled activation edge, touch or release
  assign change = |(((act_a_in ^ prev_a) & en_a_in) |
                    ((act_b_in ^ prev_b) & en_b_in));
  assign both_read = (seen_a | rd_a_in) & (seen_b | rd_b_in);
  assign next_pending_out = change | (pending_out & ~both_read);

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      prev_a <= '0;
      prev_b <= '0;
    end else begin
      prev_a <= act_a_in;
      prev_b <= act_b_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      pending_out <= 1'b0;
    end else begin
      pending_out <= next_pending_out;
    end
  end

  // reads only count once a request stands; a new change restarts the pair
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      seen_a <= 1'b0;
      seen_b <= 1'b0;
    end else if (change || !next_pending_out) begin
      seen_a <= 1'b0;
      seen_b <= 1'b0;
    end else if (pending_out) begin
      seen_a <= seen_a | rd_a_in;
      seen_b <= seen_b | rd_b_in;
    end
  end

endmodule : tsirq_touch_watch

`default_nettype wire
